/* File: core/serial_function_selector.sv */
module serial_function_selector
   import sfs_pkg::*;
#(
   parameter logic [3:0] HAS_FUNC = 4'hF,
   // identifier values below are arbitrary
   parameter logic [19:0] INSTANCE_ID = 20'hA5A5A,
   parameter logic [15:0] ASYNC_MODID = 16'h1111,
   parameter logic [15:0] SPI_MODID = 16'h2222,
   parameter logic [15:0] I2C_MODID = 16'h3333,
   parameter logic [15:0] I2STX_MODID = 16'h4444,
   parameter logic [15:0] I2SRX_MODID = 16'h5555,
   parameter logic [3:0] FUNC_MAJOR = 4'h1,
   parameter logic [3:0] FUNC_MINOR = 4'h0
)
(
   input wire logic clock,
   input wire logic rst,
   input wire logic ifaceRst,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [11:0] regAddr,
   input wire logic [31:0] regWdata,
   output logic [31:0] regRdata,
   output logic [2:0] activeFunc
);
   // ==========================================================
   // state
   logic [2:0] functionCode_ff;
   logic lock_ff;
   logic [31:0] rdata_ff;
   logic [2:0] active_ff;

   // ==========================================================
   // next values
   logic [2:0] nxt_functionCode;
   logic nxt_lock;
   logic [31:0] nxt_rdata;
   logic [2:0] nxt_active;

   // ==========================================================
   // code checker
   // validity lives in its own module so the rule sits in one place
   sfs_sel_if sel();

   assign sel.code = functionCode_ff;
   assign sel.avail = HAS_FUNC;

   sfs_code_check u_check
   (
      .sel(sel)
   );

   // ==========================================================
   // address decode
   // full-word offsets only; byte lanes are not decoded
   wire selHit = (regAddr == SFS_SEL_OFFSET);
   wire identHit = (regAddr == SFS_IDENT_OFFSET);

   wire selWrite = regWrite && selHit;
   wire selRead = regRead && selHit;
   wire identRead = regRead && identHit;

   // ==========================================================
   // write data fields
   // reserved bits 11:8 are not stored
   wire [2:0] wrCode = regWdata[SFS_CODE_MSB:SFS_CODE_LSB];
   wire wrLock = regWdata[SFS_LOCK_BIT];

   // ==========================================================
   // function code and lock update
   // lock only blocks code changes; lock itself stays set until reset
   wire codeWrite = selWrite && !lock_ff;
   wire lockSet = selWrite && wrLock;

   assign nxt_functionCode = codeWrite ? wrCode : functionCode_ff;
   // code and lock in one word: the code still lands, then freezes
   assign nxt_lock = lock_ff | lockSet;

   // ==========================================================
   // enabled function
   // reserved or absent codes stay stored but drive no core
   assign nxt_active = sel.valid ? functionCode_ff : SFS_FN_NONE;

   // ==========================================================
   // module identifier per function
   logic [15:0] modId;
   always_comb
   begin
      modId = 16'h0000;
      unique case (functionCode_ff)
         SFS_FN_ASYNC: modId = ASYNC_MODID;
         SFS_FN_SPI: modId = SPI_MODID;
         SFS_FN_I2C: modId = I2C_MODID;
         SFS_FN_I2S_TX: modId = I2STX_MODID;
         SFS_FN_I2S_RX: modId = I2SRX_MODID;
         default: modId = 16'h0000;
      endcase
   end

   // ==========================================================
   // select register word
   wire [31:0] selWord;

   assign selWord[SFS_CODE_MSB:SFS_CODE_LSB] = functionCode_ff;
   assign selWord[SFS_LOCK_BIT] = lock_ff;
   // undefined to software; zero keeps the read path simple
   assign selWord[11:8] = 4'h0;
   // instance id is fixed per build
   assign selWord[SFS_INST_MSB:SFS_INST_LSB] = INSTANCE_ID;

   // ==========================================================
   // presence bits, one per function family
   // hard-wired, so writes to 7:4 fall on nothing
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1)
      begin : g_avail
         assign selWord[SFS_AVAIL_LSB + g] = HAS_FUNC[g];
      end
   endgenerate

   // ==========================================================
   // identification register word
   wire [3:0] identMajor = FUNC_MAJOR;
   wire [3:0] identMinor = FUNC_MINOR;
   wire [31:0] identFull;
   wire [31:0] identWord;

   assign identFull[SFS_MODID_MSB:SFS_MODID_LSB] = modId;
   assign identFull[SFS_MAJOR_MSB:SFS_MAJOR_LSB] = identMajor;
   assign identFull[SFS_MINOR_MSB:SFS_MINOR_LSB] = identMinor;
   assign identFull[7:0] = 8'h00;
   // zero unless a present function is chosen
   assign identWord = sel.valid ? identFull : 32'h0000_0000;

   // ==========================================================
   // read data select
   // idle and unmapped reads return zero, so slots can be or-ed
   wire [31:0] selPart = selRead ? selWord : 32'h0000_0000;
   wire [31:0] identPart = identRead ? identWord : 32'h0000_0000;

   assign nxt_rdata = selPart | identPart;

   // ==========================================================
   // reset
   // either source clears the whole slot, lock included
   wire anyRst = rst | ifaceRst;

   // ==========================================================
   // function code register
   // reserved codes are kept so software reads back what it wrote
   always_ff @(posedge clock)
   begin
      if (anyRst)
      begin
         functionCode_ff <= SFS_CODE_RESET;
      end
      else
      begin
         functionCode_ff <= nxt_functionCode;
      end
   end

   // ==========================================================
   // lock register
   // no clear path: only a reset reopens the select
   always_ff @(posedge clock)
   begin
      if (anyRst)
      begin
         lock_ff <= SFS_LOCK_RESET;
      end
      else
      begin
         lock_ff <= nxt_lock;
      end
   end

   // ==========================================================
   // read data register
   // one-cycle answer, zero between reads
   always_ff @(posedge clock)
   begin
      if (anyRst)
      begin
         rdata_ff <= 32'h0000_0000;
      end
      else
      begin
         rdata_ff <= nxt_rdata;
      end
   end

   // ==========================================================
   // active function register
   // one cycle behind the code, so cores see a clean level
   always_ff @(posedge clock)
   begin
      if (anyRst)
      begin
         active_ff <= SFS_FN_NONE;
      end
      else
      begin
         active_ff <= nxt_active;
      end
   end

   // ==========================================================
   // outputs
   assign regRdata = rdata_ff;
   assign activeFunc = active_ff;
endmodule

/* File: core/sfs_pkg.sv */
package sfs_pkg;
   // ==========================================================
   // register map
   localparam logic [11:0] SFS_SEL_OFFSET = 12'hFF8;
   localparam logic [11:0] SFS_IDENT_OFFSET = 12'hFFC;

   // ==========================================================
   // select register fields
   localparam int SFS_CODE_LSB = 0;
   localparam int SFS_CODE_MSB = 2;
   localparam int SFS_LOCK_BIT = 3;
   localparam int SFS_AVAIL_LSB = 4;
   localparam int SFS_AVAIL_MSB = 7;
   localparam int SFS_INST_LSB = 12;
   localparam int SFS_INST_MSB = 31;
   localparam logic [2:0] SFS_CODE_RESET = 3'h0;
   localparam logic SFS_LOCK_RESET = 1'b0;

   // ==========================================================
   // ident register fields
   localparam int SFS_MINOR_LSB = 8;
   localparam int SFS_MINOR_MSB = 11;
   localparam int SFS_MAJOR_LSB = 12;
   localparam int SFS_MAJOR_MSB = 15;
   localparam int SFS_MODID_LSB = 16;
   localparam int SFS_MODID_MSB = 31;

   // ==========================================================
   // function codes
   typedef enum logic [2:0]
   {
      SFS_FN_NONE = 3'h0,
      SFS_FN_ASYNC = 3'h1,
      SFS_FN_SPI = 3'h2,
      SFS_FN_I2C = 3'h3,
      SFS_FN_I2S_TX = 3'h4,
      SFS_FN_I2S_RX = 3'h5
   } sfs_func_t;
endpackage

/* File: core/sfs_sel_if.sv */
interface sfs_sel_if;
   import sfs_pkg::*;
   logic [2:0] code;
   logic [3:0] avail;
   logic valid;
   modport owner (output code, output avail, input valid);
   modport check (input code, input avail, output valid);
endinterface

/* File: core/sfs_code_check.sv */
module sfs_code_check
   import sfs_pkg::*;
(
   sfs_sel_if.check sel
);
   // avail bit order: async, spi, i2c, i2s
   wire isAsync = (sel.code == SFS_FN_ASYNC) && sel.avail[0];
   wire isSpi = (sel.code == SFS_FN_SPI) && sel.avail[1];
   wire isI2c = (sel.code == SFS_FN_I2C) && sel.avail[2];
   wire isI2s = ((sel.code == SFS_FN_I2S_TX) ||
                 (sel.code == SFS_FN_I2S_RX)) && sel.avail[3];
   // reserved codes and absent functions fall out as invalid
   assign sel.valid = isAsync | isSpi | isI2c | isI2s;
endmodule

/* File: bench/sfs_checker.sv */
module sfs_checker
   import sfs_pkg::*;
#(parameter logic [3:0] HAS_FUNC = 4'hF)
(
   input wire logic clock,
   input wire logic rst,
   input wire logic ifaceRst,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [11:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic [31:0] regRdata,
   input wire logic [2:0] activeFunc
);
   // ==========================================================
   // read tracking
   logic rd_ff;
   logic [11:0] ad_ff;
   always_ff @(posedge clock)
   begin
      rd_ff <= regRead;
      ad_ff <= regAddr;
   end
   default clocking @(posedge clock); endclocking
   default disable iff (rst || ifaceRst);
   idle_zero_a: assert property (!rd_ff |-> regRdata == 32'h0)
      else $error("data while idle");
   unmapped_zero_a: assert property (rd_ff && ad_ff != 12'hFF8 &&
      ad_ff != 12'hFFC |-> regRdata == 32'h0) else $error("unmapped data");
   avail_bits_a: assert property (rd_ff && ad_ff == 12'hFF8
      |-> regRdata[7:4] == HAS_FUNC) else $error("avail bits");
   ident_low_a: assert property (rd_ff && ad_ff == 12'hFFC
      |-> regRdata[7:0] == 8'h0) else $error("ident low byte");
   ident_none_a: assert property (rd_ff && ad_ff == 12'hFFC &&
      activeFunc == 3'h0 |-> regRdata == 32'h0) else $error("ident not 0");
   ident_rev_a: assert property (rd_ff && ad_ff == 12'hFFC &&
      activeFunc != 3'h0 |-> regRdata[15:8] == 8'h10) else $error("rev");
   func_legal_a: assert property (activeFunc <= 3'h5)
      else $error("bad function");
   func_cause_a: assert property ($changed(activeFunc) |->
      $past(regWrite, 2) || $past(rst) || $past(ifaceRst))
      else $error("function moved");
   cover property (regWrite && regAddr == 12'hFF8);
   cover property (rd_ff && ad_ff == 12'hFFC && activeFunc != 3'h0);
   cover property (activeFunc == 3'h3);
endmodule

/* File: bench/serial_function_selector_tb_top.sv */
module serial_function_selector_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 0, rst = 1, ifaceRst = 0, regWrite = 0, regRead = 0;
   logic [11:0] regAddr = 0;
   logic [31:0] regWdata = 0, regRdata, exp;
   logic [2:0] activeFunc;
   int error_cnt = 0, tests_run = 0, cyc = 0;
   serial_function_selector #(.HAS_FUNC(4'h7)) i_serial_function_selector
      (.clock(clock), .rst(rst), .ifaceRst(ifaceRst), .regWrite(regWrite),
      .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
      .regRdata(regRdata), .activeFunc(activeFunc));
   initial forever #4 clock = ~clock;
   // ==========================================================
   // access tasks
   task automatic results;
      if (error_cnt == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   always @(posedge clock)
      if (++cyc == 1000)
      begin
         error_cnt++;
         results;
      end
   task automatic cmp(input logic [31:0] got, input logic [31:0] want);
      tests_run++;
      if (got !== want)
      begin
         error_cnt++;
         $display("mismatch %0t got %h want %h", $time, got, want);
      end
   endtask
   task automatic cmpFunc(input logic [2:0] got, input logic [2:0] want);
      tests_run++;
      if (got !== want)
      begin
         error_cnt++;
         $display("mismatch %0t func got %h want %h", $time, got, want);
      end
   endtask
   // idle cycle at the end keeps strobes from being set twice in a step
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      regAddr = a;
      regWdata = d;
      regWrite = 1;
      @(posedge clock) #1 regWrite = 0;
      @(posedge clock) #1;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] want);
      regAddr = a;
      regRead = 1;
      @(posedge clock) #1 regRead = 0;
      cmp(regRdata, want);
      @(posedge clock) #1;
   endtask
   initial
   begin
      repeat (20) @(posedge clock);
      #1 rst = 0;
      rd(12'hFF8, 32'hA5A5A070);
      rd(12'hFFC, 32'h0);
      for (int c = 1; c < 8; c++)
      begin
         wr(12'hFF8, c | 32'hF0);
         exp = c < 4 ? {16'(16'h1111 * c), 16'h1000} : 32'h0;
         rd(12'hFFC, exp);
         cmpFunc(activeFunc, c < 4 ? 3'(c) : 3'h0);
         rd(12'hFF8, 32'hA5A5A070 | c);
      end
      wr(12'hFF8, 32'hB);
      wr(12'hFFC, 32'hFFFFFFFF);
      wr(12'hFF8, 32'h1);
      rd(12'hFF8, 32'hA5A5A07B);
      rd(12'hFFC, 32'h33331000);
      rd(12'h000, 32'h0);
      ifaceRst = 1;
      @(posedge clock) #1 ifaceRst = 0;
      rd(12'hFF8, 32'hA5A5A070);
      wr(12'hFF8, 32'h2);
      rd(12'hFF8, 32'hA5A5A072);
      results;
   end
endmodule
bind serial_function_selector sfs_checker #(.HAS_FUNC(4'h7)) i_sfs_checker
   (.clock(clock), .rst(rst), .ifaceRst(ifaceRst), .regWrite(regWrite),
   .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
   .regRdata(regRdata), .activeFunc(activeFunc));
